/* File: udg_device.sv */
/*
  udg_device: device end holding the transaction status words, the
  write protect lock and the scratch register, all reached by commands.
  assumes: the transaction engine reports one result per pulse on
  the same clock; suspend_in is synchronous to ref_clk_in.
*/
// Notes on behaviour
// - sixteen status read codes, one word each
// - each new transaction replaces stored status
// - bit7 set when event precedes status read
// - bit6 holds toggle of last good packet
// - error code in bits 4..1, bit5 zero
// - bit0 set on successful transfer
// - code 0 for no error, codes 1,2 for PID errors
// - code 3 for unexpected packet
// - codes 4..8 for CRC, timeout, babble, EOP
// - codes 9 NAK, 10 stall sent
// - code 11 for buffer overflow
// - codes 12..15; bad toggle data ignored
// - suspend blocks all register writes
// - after resume reads refused until unlock
// - unlock code plus key lifts protection
// - processor unlocks after every wake-up
// - scratch written and read by commands
// - scratch 13 bits, reset zero, upper zero
`timescale 1ns/1ps
module udg_device (
  input  wire logic       ref_clk_in,     // 100 MHz clock
  input  wire logic       arst_n_in,      // async reset, low
  udg_if.dev              bus,            // host bus
  input  wire logic       suspend_in,     // device in suspend
  input  wire logic       txn_done_in,    // transaction result pulse
  input  wire logic [3:0] txn_ep_in,      // endpoint index
  input  wire logic [3:0] txn_err_in,     // error code
  input  wire logic       txn_ok_in,      // transfer succeeded
  input  wire logic       txn_toggle_in,  // data toggle of packet
  output logic            locked_out      // write protection active
);
  import udg_pkg::*;

  // a packet counts as good only when the engine reports no error code
  function automatic logic good_packet(input logic       ok,
                                       input logic [3:0] err);
    return ok && err == ERR_NONE;
  endfunction : good_packet

  // every status code shares one upper nibble, the lower one is the index
  function automatic logic status_code(input logic [7:0] code);
    return code[7:4] == CMD_STATUS_BASE[7:4];
  endfunction : status_code

  logic [7:0]           status_q [EP_COUNT];
  logic [7:0]           status_d [EP_COUNT];
  logic [EP_COUNT-1:0]  pending_q;
  logic [EP_COUNT-1:0]  pending_d;

  logic [SCRATCH_W-1:0] scratch_q;
  logic [SCRATCH_W-1:0] scratch_d;
  logic [7:0]           cmd_q;
  logic [7:0]           cmd_d;
  logic                 armed_q;
  logic                 armed_d;
  logic                 locked_q;
  logic                 locked_d;
  logic [15:0]          rdata_q;
  logic [15:0]          rdata_d;
  logic                 rvalid_q;
  logic                 rvalid_d;

  logic                 cmd_wr;
  logic                 data_rd;
  logic                 data_wr;
  logic                 is_status;
  logic                 read_open;
  logic [3:0]           sel_ep;
  logic                 txn_good;

  assign cmd_wr    = bus.cs && bus.is_cmd && bus.wr;
  assign data_rd   = bus.cs && !bus.is_cmd && !bus.wr && armed_q;
  assign data_wr   = bus.cs && !bus.is_cmd && bus.wr && armed_q;
  assign is_status = status_code(cmd_q);
  assign sel_ep    = cmd_q[3:0];
  // refused for as long as the lock stands, not only while suspended
  assign read_open = data_rd && !locked_q;
  assign txn_good  = good_packet(txn_ok_in, txn_err_in);

  // command decode: a command phase latches the code and arms one word
  always_comb begin
    cmd_d   = cmd_q;
    armed_d = armed_q;
    if (cmd_wr) begin
      cmd_d   = bus.wdata[7:0];
      armed_d = 1'b1;
    end else if (data_rd || data_wr) begin
      armed_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmd_q   <= 8'h00;
      armed_q <= 1'b0;
    end else begin
      cmd_q   <= cmd_d;
      armed_q <= armed_d;
    end
  end

  // lock: suspend wins over a key word in the same cycle, so wake-up
  // noise on the bus cannot open the device early
  always_comb begin
    locked_d = locked_q;
    if (suspend_in) begin
      locked_d = 1'b1;
    end else if (data_wr && cmd_q == CMD_UNLOCK
                 && bus.wdata == UNLOCK_KEY) begin
      locked_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= locked_d;
    end
  end

  // scratch: a write needs both the lock open and suspend gone
  always_comb begin
    scratch_d = scratch_q;
    if (data_wr && cmd_q == CMD_SCRATCH_WR && !locked_q
        && !suspend_in) begin
      scratch_d = bus.wdata[SCRATCH_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scratch_q <= SCRATCH_RESET;
    end else begin
      scratch_q <= scratch_d;
    end
  end

  // read answer: a refused read still answers, with zero, so the host
  // never waits on a word that will not come
  always_comb begin
    rdata_d  = 16'h0000;
    rvalid_d = data_rd;
    if (read_open) begin
      if (is_status) begin
        rdata_d = {8'h00, status_q[sel_ep]};
      end else if (cmd_q == CMD_SCRATCH_RD) begin
        rdata_d = {3'b000, scratch_q};
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // status: a status read drops the pending mark; a new result in the
  // same cycle sets it again, so the set wins
  always_comb begin
    pending_d = pending_q;
    for (int i = 0; i < EP_COUNT; i++) begin
      status_d[i] = status_q[i];
    end
    if (read_open && is_status) begin
      pending_d[sel_ep] = 1'b0;
    end
    if (txn_done_in) begin
      status_d[txn_ep_in][BIT_MISSED]   = pending_d[txn_ep_in];
      status_d[txn_ep_in][BIT_RESERVED] = 1'b0;
      // the engine's code is kept as reported, the old result dropped
      status_d[txn_ep_in][ERR_LSB +: 4] = txn_err_in;
      status_d[txn_ep_in][BIT_OK]       = txn_good;
      // toggle follows only good packets; wrong-toggle data is dropped
      if (txn_good) begin
        status_d[txn_ep_in][BIT_TOGGLE] = txn_toggle_in;
      end
      pending_d[txn_ep_in] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < EP_COUNT; i++) begin
        status_q[i] <= STATUS_RESET;
      end
      pending_q <= '0;
    end else begin
      status_q  <= status_d;
      pending_q <= pending_d;
    end
  end

  assign bus.rdata  = rdata_q;
  assign bus.rvalid = rvalid_q;
  assign locked_out = locked_q;
endmodule : udg_device

/* File: udg_pkg.sv */
/*
  udg_pkg: constants shared by both ends of the general-command register
  link: command codes, status word layout, error codes, unlock key.
  assumes: included before the interface and both end modules.
*/
package udg_pkg;
  localparam logic [7:0]  CMD_STATUS_BASE  = 8'hA0;
  localparam logic [7:0]  CMD_STATUS_LAST  = 8'hAF;
  localparam logic [7:0]  CMD_UNLOCK       = 8'hB0;
  localparam logic [7:0]  CMD_SCRATCH_WR   = 8'hB2;
  localparam logic [7:0]  CMD_SCRATCH_RD   = 8'hB3;
  localparam logic [15:0] UNLOCK_KEY       = 16'hAA37;
  localparam int          EP_COUNT         = 16;
  localparam int          BIT_MISSED       = 7;
  localparam int          BIT_TOGGLE       = 6;
  localparam int          BIT_RESERVED     = 5;
  localparam int          ERR_LSB          = 1;
  localparam int          BIT_OK           = 0;
  localparam int          SCRATCH_W        = 13;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;
  localparam logic [12:0] SCRATCH_RESET    = 13'h0000;
  localparam logic [3:0]  ERR_NONE         = 4'h0;
  localparam logic [3:0]  ERR_PID_ENC      = 4'h1;
  localparam logic [3:0]  ERR_PID_UNKNOWN  = 4'h2;
  localparam logic [3:0]  ERR_UNEXPECTED   = 4'h3;
  localparam logic [3:0]  ERR_TOKEN_CRC    = 4'h4;
  localparam logic [3:0]  ERR_DATA_CRC     = 4'h5;
  localparam logic [3:0]  ERR_TIMEOUT      = 4'h6;
  localparam logic [3:0]  ERR_BABBLE       = 4'h7;
  localparam logic [3:0]  ERR_EOP          = 4'h8;
  localparam logic [3:0]  ERR_NAK          = 4'h9;
  localparam logic [3:0]  ERR_STALL        = 4'hA;
  localparam logic [3:0]  ERR_OVERFLOW     = 4'hB;
  localparam logic [3:0]  ERR_ISO_EMPTY    = 4'hC;
  localparam logic [3:0]  ERR_BITSTUFF     = 4'hD;
  localparam logic [3:0]  ERR_SYNC         = 4'hE;
  localparam logic [3:0]  ERR_TOGGLE       = 4'hF;
  typedef enum logic [1:0] {
    UDG_IDLE = 2'b00,
    UDG_CMD  = 2'b01,
    UDG_DATA = 2'b11,
    UDG_DONE = 2'b10
  } udg_hstate_t;
endpackage : udg_pkg

/* File: udg_if.sv */
/*
  udg_if: the shared parallel bus between host processor and device.
  assumes: one clock; a strobe marks a one-cycle bus cycle.
*/
`timescale 1ns/1ps
interface udg_if;
  logic        cs;      // bus cycle strobe, one cycle
  logic        is_cmd;  // 1: command phase, 0: data phase
  logic        wr;      // 1: write, 0: read
  logic [15:0] wdata;   // host write data
  logic [15:0] rdata;   // device read data
  logic        rvalid;  // read data valid, one cycle
  modport dev  (input cs, is_cmd, wr, wdata, output rdata, rvalid);
  modport host (output cs, is_cmd, wr, wdata, input rdata, rvalid);
endinterface : udg_if

/* File: udg_host.sv */
/*
  udg_host: processor end; turns a user request into a command phase
  and one data word, and returns read data.
  assumes: device answers a read one cycle after the data strobe.
*/
`timescale 1ns/1ps
module udg_host (
  input  wire logic        ref_clk_in,  // 100 MHz clock
  input  wire logic        arst_n_in,   // async reset, low
  udg_if.host              bus,         // device bus
  input  wire logic        req_in,      // start request, pulse
  input  wire logic [7:0]  cmd_in,      // command code
  input  wire logic        wr_in,       // 1: write data word
  input  wire logic [15:0] wdata_in,    // word to write
  output logic             busy_out,    // request in flight
  output logic             done_out,    // request finished, pulse
  output logic [15:0]      rdata_out    // word read back
);
  import udg_pkg::*;

  udg_hstate_t st_q;
  udg_hstate_t st_d;
  logic [7:0]  cmd_q;
  logic [7:0]  cmd_d;
  logic        wr_q;
  logic        wr_d;
  logic [15:0] wd_q;
  logic [15:0] wd_d;
  logic [15:0] rd_q;
  logic [15:0] rd_d;
  logic        cs_q;
  logic        cs_d;
  logic        iscmd_q;
  logic        iscmd_d;
  logic        bwr_q;
  logic        bwr_d;
  logic [15:0] bwd_q;
  logic [15:0] bwd_d;
  logic        done_q;
  logic        done_d;
  logic        busy_q;
  logic        busy_d;

  always_comb begin
    st_d    = st_q;
    cmd_d   = cmd_q;
    wr_d    = wr_q;
    wd_d    = wd_q;
    rd_d    = rd_q;
    cs_d    = 1'b0;
    iscmd_d = 1'b0;
    bwr_d   = 1'b0;
    bwd_d   = 16'h0000;
    done_d  = 1'b0;
    case (st_q)
      UDG_IDLE: begin
        if (req_in) begin
          cmd_d = cmd_in;
          wr_d  = wr_in;
          // reserved scratch bits are kept at zero
          wd_d = (cmd_in == CMD_SCRATCH_WR)
                 ? {3'b000, wdata_in[SCRATCH_W-1:0]} : wdata_in;
          st_d = UDG_CMD;
        end
      end
      UDG_CMD: begin
        cs_d    = 1'b1;
        iscmd_d = 1'b1;
        bwr_d   = 1'b1;
        bwd_d   = {8'h00, cmd_q};
        st_d    = UDG_DATA;
      end
      UDG_DATA: begin
        cs_d  = 1'b1;
        bwr_d = wr_q;
        bwd_d = wr_q ? wd_q : 16'h0000;
        st_d  = UDG_DONE;
      end
      UDG_DONE: begin
        // a read waits for the answer; a write ends at once
        if (wr_q || bus.rvalid) begin
          if (!wr_q) begin
            rd_d = bus.rdata;
          end
          done_d = 1'b1;
          st_d   = UDG_IDLE;
        end
      end
      default: begin
        st_d = UDG_IDLE;
      end
    endcase
    // registered so that busy comes from a flop like every output
    busy_d = st_d != UDG_IDLE;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q    <= UDG_IDLE;
      cmd_q   <= 8'h00;
      wr_q    <= 1'b0;
      wd_q    <= 16'h0000;
      rd_q    <= 16'h0000;
      cs_q    <= 1'b0;
      iscmd_q <= 1'b0;
      bwr_q   <= 1'b0;
      bwd_q   <= 16'h0000;
      done_q  <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      cmd_q   <= cmd_d;
      wr_q    <= wr_d;
      wd_q    <= wd_d;
      rd_q    <= rd_d;
      cs_q    <= cs_d;
      iscmd_q <= iscmd_d;
      bwr_q   <= bwr_d;
      bwd_q   <= bwd_d;
      done_q  <= done_d;
      busy_q  <= busy_d;
    end
  end

  assign bus.cs     = cs_q;
  assign bus.is_cmd = iscmd_q;
  assign bus.wr     = bwr_q;
  assign bus.wdata  = bwd_q;
  assign busy_out   = busy_q;
  assign done_out   = done_q;
  assign rdata_out  = rd_q;
endmodule : udg_host

/* File: udg_sva.sv */
/*
  udg_sva: concurrent checks on the host/device command bus.
  assumes: instantiated beside the bus interface, sees its signals plainly.
*/
`timescale 1ns/1ps
module udg_sva
  import udg_pkg::*;
(
  input wire logic        ref_clk_in,  // bus clock
  input wire logic        arst_n_in,   // async reset, low
  input wire logic        cs,          // bus cycle strobe
  input wire logic        is_cmd,      // command phase
  input wire logic        wr,          // write cycle
  input wire logic [15:0] wdata,       // host data
  input wire logic [15:0] rdata,       // device data
  input wire logic        rvalid       // read data valid
);
  logic [7:0] code_q;
  logic [7:0] code_d;
  logic       armed_q;
  logic       armed_d;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // code stays until the next command, so it still names the answer
  always_comb begin
    code_d  = code_q;
    armed_d = armed_q;
    if (cs && is_cmd && wr) begin
      code_d  = wdata[7:0];
      armed_d = 1'b1;
    end else if (cs && !is_cmd) begin
      armed_d = 1'b0;
    end
  end
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      code_q  <= 8'h00;
      armed_q <= 1'b0;
    end else begin
      code_q  <= code_d;
      armed_q <= armed_d;
    end
  end
  a_rvalid_pulse: assert property (rvalid |=> !rvalid)
    else $error("read answer longer than one cycle");
  a_idle_rdata: assert property (!rvalid |-> rdata == 16'h0000)
    else $error("read data not zero outside answer");
  a_read_answer: assert property (
    cs && !is_cmd && !wr && armed_q |=> rvalid)
    else $error("armed read not answered");
  a_no_stray_answer: assert property (
    rvalid |-> $past(cs && !is_cmd && !wr && armed_q))
    else $error("answer without armed read");
  a_status_reserved: assert property (
    rvalid && code_q[7:4] == CMD_STATUS_BASE[7:4]
    |-> rdata[15:8] == 8'h00 && !rdata[BIT_RESERVED])
    else $error("status reserved bits set");
  a_ok_no_error: assert property (
    rvalid && code_q[7:4] == CMD_STATUS_BASE[7:4] && rdata[BIT_OK]
    |-> rdata[ERR_LSB +: 4] == ERR_NONE)
    else $error("success flag with error code");
  a_scratch_upper: assert property (
    rvalid && code_q == CMD_SCRATCH_RD |-> rdata[15:13] == 3'h0)
    else $error("scratch upper bits set");
  a_other_zero: assert property (
    rvalid && code_q[7:4] != CMD_STATUS_BASE[7:4]
    && code_q != CMD_SCRATCH_RD
    |-> rdata == 16'h0000)
    else $error("unknown code read not zero");
  a_cmd_then_data: assert property (cs && is_cmd |=> cs && !is_cmd)
    else $error("command not followed by data word");
  a_data_single: assert property (cs && !is_cmd |=> !cs)
    else $error("more than one data word");
endmodule : udg_sva

/* File: usb_device_general_cmd_regs_test.sv */
/*
  usb_device_general_cmd_regs_test: host end and device end joined by the
  bus interface; random and corner traffic, self-checking.
  assumes: udg_pkg, udg_if, udg_host, udg_device and udg_sva compiled first.
*/
`timescale 1ns/1ps
module usb_device_general_cmd_regs_test;
  import udg_pkg::*;
  logic        ref_clk_in, arst_n_in, suspend_in, req_in, wr_in;
  logic        txn_done_in, txn_ok_in, txn_toggle_in;
  logic        busy_out, done_out, locked_out;
  logic [3:0]  txn_ep_in, txn_err_in, ep;
  logic [7:0]  cmd_in;
  logic [15:0] wdata_in, rdata_out, r, keep;
  logic [15:0] exp_m [16];
  logic        tog_m [16];
  logic        pend_m [16];
  int          n_errors, checked, seed;
  udg_if bus_if ();
  udg_host udg_host_i (.ref_clk_in, .arst_n_in, .bus(bus_if), .req_in,
    .cmd_in, .wr_in, .wdata_in, .busy_out, .done_out, .rdata_out);
  udg_device udg_device_i (.ref_clk_in, .arst_n_in, .bus(bus_if),
    .suspend_in, .txn_done_in, .txn_ep_in, .txn_err_in, .txn_ok_in,
    .txn_toggle_in, .locked_out);
  udg_sva udg_sva_i (.ref_clk_in, .arst_n_in, .cs(bus_if.cs),
    .is_cmd(bus_if.is_cmd), .wr(bus_if.wr), .wdata(bus_if.wdata),
    .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic req(input logic [7:0] c, input logic w,
                     input logic [15:0] d, output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    #1;
    req_in = 1'b1;
    cmd_in = c;
    wr_in = w;
    wdata_in = d;
    @(posedge ref_clk_in);
    #1;
    req_in = 1'b0;
    chk({15'h0000, busy_out}, 16'h0001);
    while (done_out !== 1'b1 && n < 20) begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    if (n == 20) begin
      n_errors++;
      conclude();
    end
    chk({15'h0000, busy_out}, 16'h0000);
    rd = rdata_out;
  endtask : req
  function automatic logic [15:0] st_word(logic u, logic t, logic [3:0] e,
                                          logic ok);
    return {8'h00, u, t, 1'b0, e, ok && e == ERR_NONE};
  endfunction : st_word
  task automatic txn(input logic [3:0] e, input logic [3:0] err,
                     input logic ok);
    @(posedge ref_clk_in);
    #1;
    txn_done_in = 1'b1;
    txn_ep_in = e;
    txn_err_in = err;
    txn_ok_in = ok;
    txn_toggle_in = 1'($random(seed));
    @(posedge ref_clk_in);
    #1;
    txn_done_in = 1'b0;
    // toggle follows only packets that went through cleanly
    if (ok && err == ERR_NONE) tog_m[e] = txn_toggle_in;
    exp_m[e] = st_word(pend_m[e], tog_m[e], err, ok);
    pend_m[e] = 1'b1;
  endtask : txn
  initial begin
    seed = 14;
    n_errors = 0;
    checked = 0;
    arst_n_in = 1'b0;
    {suspend_in, req_in, wr_in, txn_done_in, txn_ok_in} = '0;
    {txn_toggle_in, txn_ep_in, txn_err_in, cmd_in, wdata_in} = '0;
    for (int i = 0; i < 16; i++) begin
      exp_m[i] = 16'h0000;
      tog_m[i] = 1'b0;
      pend_m[i] = 1'b0;
    end
    repeat (6) @(posedge ref_clk_in);
    #1 arst_n_in = 1'b1;
    for (int i = 0; i < 16; i++) begin
      req(CMD_STATUS_BASE | 8'(i), 1'b0, 16'h0000, r);
      chk(r, 16'h0000);
    end
    req(CMD_SCRATCH_RD, 1'b0, 16'h0000, r);
    chk(r, 16'h0000);
    req(8'hB1, 1'b0, 16'h0000, r);
    chk(r, 16'h0000);
    $display("test reset values done");
    repeat (6) begin
      keep = 16'($random(seed));
      req(CMD_SCRATCH_WR, 1'b1, keep, r);
      req(CMD_SCRATCH_RD, 1'b0, 16'h0000, r);
      chk(r, keep & 16'h1FFF);
    end
    $display("test scratch done");
    for (int c = 0; c < 16; c++) begin
      ep = 4'($random(seed));
      txn(ep, 4'(c), 1'($random(seed)));
      if (c % 4 == 0) txn(ep, 4'(15 - c), 1'($random(seed)));
      req(CMD_STATUS_BASE | {4'h0, ep}, 1'b0, 16'h0000, r);
      chk(r, exp_m[ep]);
      pend_m[ep] = 1'b0;
    end
    // corner: a clean packet sets bit 0, a wrong toggle keeps bit 6
    for (int k = 0; k < 2; k++) begin
      txn(4'h5, (k == 0) ? ERR_NONE : ERR_TOGGLE, 1'b1);
      req(CMD_STATUS_BASE | 8'h05, 1'b0, 16'h0000, r);
      chk(r, exp_m[5]);
      pend_m[5] = 1'b0;
    end
    $display("test status codes done");
    @(posedge ref_clk_in);
    #1 suspend_in = 1'b1;
    req(CMD_SCRATCH_WR, 1'b1, 16'h0ABC, r);
    req(CMD_UNLOCK, 1'b1, UNLOCK_KEY, r);
    chk({15'h0000, locked_out}, 16'h0001);
    @(posedge ref_clk_in);
    #1 suspend_in = 1'b0;
    req(CMD_SCRATCH_WR, 1'b1, 16'h0555, r);
    req(CMD_STATUS_BASE | 8'h05, 1'b0, 16'h0000, r);
    chk(r, 16'h0000);
    req(CMD_SCRATCH_RD, 1'b0, 16'h0000, r);
    chk(r, 16'h0000);
    req(CMD_UNLOCK, 1'b1, 16'h1234, r);
    chk({15'h0000, locked_out}, 16'h0001);
    req(CMD_UNLOCK, 1'b1, UNLOCK_KEY, r);
    chk({15'h0000, locked_out}, 16'h0000);
    req(CMD_SCRATCH_RD, 1'b0, 16'h0000, r);
    chk(r, keep & 16'h1FFF);
    $display("test lock done");
    @(posedge ref_clk_in);
    #1 arst_n_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1 arst_n_in = 1'b1;
    req(CMD_SCRATCH_RD, 1'b0, 16'h0000, r);
    chk(r, 16'h0000);
    req(CMD_STATUS_BASE | 8'h05, 1'b0, 16'h0000, r);
    chk(r, 16'h0000);
    $display("test mid-run reset done");
    conclude();
  end
endmodule : usb_device_general_cmd_regs_test
